// *** gss_pkg.sv ***
// shared constants, types and register map of the gated sampler sequencer
package gss_pkg;

  localparam int unsigned CLK_HZ   = 10_000_000;
  localparam int unsigned CLIP_MS  = 10;
  localparam int unsigned EXIT_MS  = 100;
  // clip hold is "about" a time; exit pulse is a longest time, so floor
  localparam int unsigned CLIP_CYC = (CLK_HZ / 1000) * CLIP_MS;
  localparam int unsigned EXIT_CYC = (CLK_HZ / 1000) * EXIT_MS;
  localparam int unsigned CNT_W    = 20;

  localparam logic [7:0]  CLIP_HI  = 8'hF0;
  localparam logic [7:0]  CLIP_LO  = 8'h0F;
  localparam logic [15:0] ADDR_TOP = 16'hFFFF;
  localparam logic [7:0]  BYTE_TOP = 8'hFF;
  localparam logic [7:0]  VAL_MAX  = 8'hFF;

  // rate generator: phase accumulator, 48 codes per octave
  localparam int unsigned ACC_W     = 18;
  localparam logic [7:0]  OCT_STEPS = 8'h30;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TUNE   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ADDR   = 8'h0C;

  // control register fields
  localparam int unsigned CTRL_W    = 6;
  localparam int unsigned CTRL_BANK = 0;
  localparam int unsigned CTRL_FUNC = 1;
  localparam int unsigned CTRL_VAR  = 3;
  localparam int unsigned CTRL_EFF  = 5;
  localparam logic [5:0]  CTRL_RST  = 6'h00;
  localparam logic [7:0]  TUNE_RST  = 8'h00;

  typedef enum logic [1:0] {
    FN_DMP  = 2'b00,
    FN_PLAY = 2'b01,
    FN_REC  = 2'b10
  } gss_func_t;

  typedef enum logic [1:0] {
    VR_LOOP = 2'b00,
    VR_NORM = 2'b01,
    VR_WAV  = 2'b10
  } gss_var_t;

  typedef enum logic [2:0] {
    MD_IDLE      = 3'h0,
    MD_REC_NORM  = 3'h1,
    MD_REC_LOOP  = 3'h2,
    MD_REC_WAV   = 3'h3,
    MD_PLAY_NORM = 3'h4,
    MD_PLAY_LOOP = 3'h5
  } gss_mode_t;

  typedef enum logic [1:0] {
    ST_WAIT   = 2'b00,
    ST_RUN    = 2'b01,
    ST_LOOPLO = 2'b11,
    ST_CLIP   = 2'b10
  } gss_state_t;

  typedef struct packed {
    logic        bank;
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } gss_mem_t;

endpackage : gss_pkg

// *** gss_rate.sv ***
// sample tick generator: control code to approximate exponential rate
`timescale 1ns/1ns
`default_nettype none
module gss_rate
  import gss_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] code,
  output logic            tick
);

  logic [7:0]       quot;
  logic [7:0]       frac;
  logic [11:0]      inc;
  logic [ACC_W:0]   sum;
  logic [ACC_W-1:0] acc_q;
  logic             tick_q;

  // mantissa 48..95 shifted by octave: about 1.8 kHz up to 77 kHz
  assign quot = code / OCT_STEPS;
  assign frac = code - 8'(quot * OCT_STEPS);
  assign inc  = 12'(OCT_STEPS + frac) << quot[2:0];
  assign sum  = {1'b0, acc_q} + (ACC_W + 1)'(inc);
  assign tick = tick_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= sum[ACC_W-1:0];
      tick_q <= sum[ACC_W];
    end
  end

endmodule : gss_rate
`default_nettype wire

// *** gss_seq.sv ***
// sampler control unit: gate merge, address sequencer, ahb-lite registers
//
// Behaviour
// - button and gate input merged into gate
// - bank switch selects memory bank
// - control value is tune plus pitch input
// - value maps to 2-79 kHz or page (the rate generator gives about 1.8-77 kHz)
// - gate low in record: monitor, indicator off
// - clip: indicator 10 ms, hold output
// - record uses rate last set monitoring
// - record: rising gate writes 0..65535
// - record stops when gate falls early
// - play: rising gate reads whole memory
// - play: new gate rise restarts at 0
// - play stops at end, no wrap
// - loop record wraps while gate high
// - loop play repeats whole memory, gate high
// - falling gate captures loop end
// - rising gate cancels captured loop end
// - short pulse under 100 ms exits loop
// - wave record writes 256-byte selected page
// - wave record uses rate from gate low
// - wave record wraps to page start
// - page re-chosen at each page end
// - falling gate halts wave record at once
// - two 64k banks, 256 pages of 256
// - sample memory keeps contents unpowered
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module gss_seq
  import gss_pkg::*;
#(
  parameter int unsigned CLIP_CYCLES = CLIP_CYC,
  parameter int unsigned EXIT_CYCLES = EXIT_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        GATE_IN,
  input  wire logic        TRIG_BTN,
  input  wire logic [7:0]  ADC_DATA,
  input  wire logic [7:0]  PITCH_CV,
  input  wire logic [7:0]  MEM_RDATA,
  output gss_mem_t         MEM_REQ,
  output logic      [7:0]  DAC_DATA,
  output logic             LED
);

  localparam logic [CNT_W-1:0] CLIP_END = CNT_W'(CLIP_CYCLES - 1);
  localparam logic [CNT_W-1:0] EXIT_LIM = CNT_W'(EXIT_CYCLES);
  localparam logic [CNT_W-1:0] CNT_SAT  = '1;

  // pin synchronisers
  logic [1:0]  gate_sy_q;
  logic [1:0]  btn_sy_q;
  logic [7:0]  adc_m_q;
  logic [7:0]  adc_q;
  logic [7:0]  cv_m_q;
  logic [7:0]  cv_q;

  // bus side
  logic [5:0]  ctrl_q;
  logic [7:0]  tune_q;
  logic        wr_pend_q;
  logic [7:0]  wr_ofs_q;
  logic [31:0] hrdata_q;
  logic        rdy_q;
  logic [31:0] rd_mux;
  logic        bus_take;

  // sequencer
  gss_state_t  st_q;
  gss_state_t  st_d;
  gss_mode_t   mode_q;
  gss_mode_t   mode;
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic [15:0] lend_q;
  logic [15:0] lend_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [7:0]  dac_q;
  logic [7:0]  dac_d;
  logic [7:0]  rate_code_q;
  logic        gate_q;
  logic        rd_pend_q;
  logic        led_q;
  logic        we_d;
  logic        re_d;
  gss_mem_t    mem_q;
  logic        tick;

  logic        gate;
  logic        rise;
  logic        fall;
  logic [8:0]  sum9;
  logic [7:0]  ctl_val;
  logic [1:0]  func;
  logic [1:0]  vsel;
  logic        rec_mode;
  logic        wrap_mode;
  logic        at_end;
  logic        start;
  logic        clip;
  logic [15:0] page_base;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      gate_sy_q <= 2'b00;
      btn_sy_q  <= 2'b00;
      adc_m_q   <= 8'h00;
      adc_q     <= 8'h00;
      cv_m_q    <= 8'h00;
      cv_q      <= 8'h00;
    end else begin
      gate_sy_q <= {gate_sy_q[0], GATE_IN};
      btn_sy_q  <= {btn_sy_q[0], TRIG_BTN};
      adc_m_q   <= ADC_DATA;
      adc_q     <= adc_m_q;
      cv_m_q    <= PITCH_CV;
      cv_q      <= cv_m_q;
    end
  end

  // ---------------- ahb-lite slave, zero wait states -----------------
  assign bus_take = HSEL & HTRANS[1] & HREADY;
  assign rd_mux =
    (HADDR[7:0] == OFS_CTRL)   ? {26'h000_0000, ctrl_q} :
    (HADDR[7:0] == OFS_TUNE)   ? {24'h00_0000, tune_q} :
    (HADDR[7:0] == OFS_STATUS) ? {16'h0000, ctl_val, 1'b0, gate,
                                  mode_q, st_q, led_q} :
    (HADDR[7:0] == OFS_ADDR)   ? {16'h0000, addr_q} : 32'h0000_0000;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
      rdy_q     <= 1'b1;
    end else begin
      wr_pend_q <= bus_take & HWRITE;
      wr_ofs_q  <= HADDR[7:0];
      rdy_q     <= 1'b1;
      if (bus_take && !HWRITE) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      ctrl_q <= CTRL_RST;
      tune_q <= TUNE_RST;
    end else if (wr_pend_q) begin
      if (wr_ofs_q == OFS_CTRL) begin
        ctrl_q <= HWDATA[CTRL_W-1:0];
      end
      if (wr_ofs_q == OFS_TUNE) begin
        tune_q <= HWDATA[7:0];
      end
    end
  end

  assign HRDATA    = hrdata_q;
  assign HREADYOUT = rdy_q;
  assign HRESP     = ~rdy_q;

  // ---------------- control decode -----------------
  assign gate = gate_sy_q[1] | btn_sy_q[1];
  assign rise = gate & ~gate_q;
  assign fall = ~gate & gate_q;

  assign sum9    = {1'b0, tune_q} + {1'b0, cv_q};
  assign ctl_val = sum9[8] ? VAL_MAX : sum9[7:0];
  assign page_base = {ctl_val, 8'h00};

  assign func = ctrl_q[CTRL_FUNC +: 2];
  assign vsel = ctrl_q[CTRL_VAR +: 2];
  // effect side and all dump modes, dump-loop included, decode idle
  assign mode =
    ctrl_q[CTRL_EFF] ? MD_IDLE :
    (func == FN_REC) ?
      ((vsel == VR_NORM) ? MD_REC_NORM :
       (vsel == VR_LOOP) ? MD_REC_LOOP :
       (vsel == VR_WAV)  ? MD_REC_WAV  : MD_IDLE) :
    (func == FN_PLAY) ?
      ((vsel == VR_NORM) ? MD_PLAY_NORM :
       (vsel == VR_LOOP) ? MD_PLAY_LOOP : MD_IDLE) :
    MD_IDLE;

  assign rec_mode  = (mode_q == MD_REC_NORM) | (mode_q == MD_REC_LOOP) |
                     (mode_q == MD_REC_WAV);
  assign wrap_mode = (mode_q == MD_REC_LOOP) | (mode_q == MD_PLAY_LOOP);
  assign at_end    = (mode_q == MD_REC_WAV) ? (addr_q[7:0] == BYTE_TOP)
                                            : (addr_q == ADDR_TOP);
  assign start     = rise & (mode_q != MD_IDLE) & (st_q != ST_LOOPLO);
  assign clip      = (adc_q > CLIP_HI) | (adc_q < CLIP_LO);

  gss_rate u_rate (
    .clk  (MCLK),
    .rst  (RST),
    .code (rate_code_q),
    .tick (tick)
  );

  // ---------------- sequencer -----------------
  always_comb begin
    st_d   = st_q;
    addr_d = addr_q;
    lend_d = lend_q;
    cnt_d  = cnt_q;
    dac_d  = dac_q;
    we_d   = 1'b0;
    re_d   = 1'b0;
    unique case (st_q)
      ST_WAIT: begin
        if (rec_mode && tick) begin
          dac_d = adc_q;
          if (clip) begin
            st_d  = ST_CLIP;
            cnt_d = '0;
          end
        end
      end
      ST_CLIP: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CLIP_END) begin
          st_d = ST_WAIT;
        end
      end
      ST_RUN: begin
        if (cnt_q != CNT_SAT) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (rec_mode && !gate) begin
          st_d = ST_WAIT;
        end else if (tick) begin
          we_d = rec_mode;
          re_d = ~rec_mode;
          if (rec_mode) begin
            dac_d = adc_q;
          end
          if (!at_end) begin
            addr_d = addr_q + 16'h0001;
          end else if (mode_q == MD_REC_WAV) begin
            addr_d = page_base;
          end else if (wrap_mode) begin
            addr_d = 16'h0000;
          end else begin
            st_d = ST_WAIT;
          end
        end
        if (mode_q == MD_PLAY_LOOP && fall) begin
          if (cnt_q < EXIT_LIM) begin
            st_d = ST_WAIT;
          end else begin
            st_d   = ST_LOOPLO;
            lend_d = addr_q;
            // a read due now is skipped so the loop end is read next
            addr_d = addr_q;
            re_d   = 1'b0;
          end
        end
      end
      ST_LOOPLO: begin
        if (tick) begin
          re_d   = 1'b1;
          addr_d = (addr_q == lend_q) ? 16'h0000
                                      : addr_q + 16'h0001;
        end
        if (rise) begin
          st_d   = ST_RUN;
          lend_d = ADDR_TOP;
          cnt_d  = '0;
        end
      end
    endcase
    if (rd_pend_q) begin
      dac_d = MEM_RDATA;
    end
    if (start) begin
      st_d   = ST_RUN;
      addr_d = (mode_q == MD_REC_WAV) ? page_base : 16'h0000;
      lend_d = ADDR_TOP;
      cnt_d  = '0;
      we_d   = 1'b0;
      re_d   = 1'b0;
    end
    if (mode != mode_q) begin
      st_d = ST_WAIT;
      we_d = 1'b0;
      re_d = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_q   <= ST_WAIT;
      mode_q <= MD_IDLE;
      addr_q <= 16'h0000;
      lend_q <= ADDR_TOP;
      cnt_q  <= '0;
      dac_q  <= 8'h00;
      gate_q <= 1'b0;
      led_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      mode_q <= mode;
      addr_q <= addr_d;
      lend_q <= lend_d;
      cnt_q  <= cnt_d;
      dac_q  <= dac_d;
      gate_q <= gate;
      led_q  <= (st_d != ST_WAIT);
    end
  end

  // rate frozen while a record run is going, live otherwise
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rate_code_q <= 8'h00;
    end else if (!(rec_mode && st_q == ST_RUN)) begin
      rate_code_q <= ctl_val;
    end
  end

  // sample store is external and non-volatile; nothing here clears it
  always_ff @(posedge MCLK) begin
    if (RST) begin
      mem_q     <= '0;
      rd_pend_q <= 1'b0;
    end else begin
      mem_q.bank  <= ctrl_q[CTRL_BANK];
      mem_q.we    <= we_d;
      mem_q.re    <= re_d;
      mem_q.addr  <= addr_q;
      mem_q.wdata <= adc_q;
      rd_pend_q   <= mem_q.re;
    end
  end

  assign MEM_REQ  = mem_q;
  assign DAC_DATA = dac_q;
  assign LED      = led_q;

  // ---------------- assertions -----------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_rec_start: assert property (
    start && mode == mode_q && mode_q == MD_REC_NORM
    |=> st_q == ST_RUN && addr_q == 16'h0000 && led_q)
    else $error("record did not start at address 0");

  a_rec_stop: assert property (
    st_q == ST_RUN && rec_mode && !gate && !start
    |=> st_q == ST_WAIT ##1 !mem_q.we)
    else $error("record kept writing after gate fell");

  a_play_keep: assert property (
    st_q == ST_RUN && mode_q == MD_PLAY_NORM && mode == mode_q &&
    fall && !(tick && at_end)
    |=> st_q == ST_RUN)
    else $error("normal play stopped on early gate fall");

  a_play_end: assert property (
    st_q == ST_RUN && mode_q == MD_PLAY_NORM && tick && at_end &&
    !start
    |=> st_q == ST_WAIT && !led_q)
    else $error("normal play wrapped past end");

  a_loop_wrap: assert property (
    st_q == ST_RUN && wrap_mode && gate && tick && at_end &&
    mode == mode_q && !fall
    |=> addr_q == 16'h0000 && st_q == ST_RUN)
    else $error("loop did not return to address 0");

  a_clip_hold: assert property (
    st_q == ST_WAIT && rec_mode && tick && clip && !start &&
    mode == mode_q
    |=> st_q == ST_CLIP ##1 (led_q && $stable(dac_q)) [*3])
    else $error("clip did not hold output and light indicator");

  a_rate_hold: assert property (
    st_q == ST_RUN && rec_mode |=> $stable(rate_code_q))
    else $error("rate changed during record");

  a_wave_page: assert property (
    st_q == ST_RUN && mode_q == MD_REC_WAV && gate && tick && at_end &&
    mode == mode_q
    |=> addr_q[7:0] == 8'h00 && addr_q[15:8] == $past(ctl_val))
    else $error("wave record did not restart page");

  a_bank_sel: assert property (
    mem_q.we |-> mem_q.bank == $past(ctrl_q[CTRL_BANK]))
    else $error("access to wrong bank");

  a_idle_mode: assert property (
    mode_q == MD_IDLE |-> st_q == ST_WAIT)
    else $error("sequencer ran in idle mode");

  c_rec_full: cover property (
    st_q == ST_RUN && mode_q == MD_REC_NORM ##1 st_q == ST_WAIT);
  c_loop_end: cover property (st_q == ST_RUN ##1 st_q == ST_LOOPLO);
  c_clip: cover property (st_q == ST_CLIP);
  c_play_retrig: cover property (
    st_q == ST_RUN && mode_q == MD_PLAY_NORM && start);

endmodule : gss_seq
`default_nettype wire

// *** gss_mem_model.sv ***
// behavioural sample memory on the far side of the sequencer
`timescale 1ns/1ns
`default_nettype none
module gss_mem_model
  import gss_pkg::*;
(
  input  wire logic     clk,
  input  wire gss_mem_t req,
  output logic [7:0]    rdata
);
  // two banks of 64k bytes, bank bit on top of the address
  logic [7:0] mem [0:131071];

  // preload stands in for contents kept over power loss
  initial begin
    rdata = 8'h00;
    for (int i = 0; i < 131072; i++) begin
      mem[i] = i[7:0] ^ i[15:8] ^ {7'h00, i[16]};
    end
  end

  always @(posedge clk) begin
    if (req.we) begin
      mem[{req.bank, req.addr}] <= req.wdata;
    end
    // answer one cycle after the read pulse, then let the data go stale
    if (req.re) begin
      rdata <= mem[{req.bank, req.addr}];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule : gss_mem_model
`default_nettype wire

// *** gated_sampler_sequencer_bench.sv ***
// self-checking bench of the sampler control unit
`timescale 1ns/1ns
`default_nettype none
module gated_sampler_sequencer_bench
  import gss_pkg::*;
;
  localparam int CLIPN = 20;
  localparam int EXITN = 50;
  localparam logic [5:0] CTL [8] = '{6'h00, 6'h0C, 6'h04, 6'h14,
                                     6'h0A, 6'h02, 6'h12, 6'h2C};
  localparam logic [2:0] MD [8] = '{3'h0, 3'h1, 3'h2, 3'h3,
                                    3'h4, 3'h5, 3'h0, 3'h0};
  logic        mclk     = 1'b0;
  logic        rst      = 1'b1;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0000_0000;
  logic [1:0]  htrans   = 2'b00;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0000_0000;
  logic        gate_in  = 1'b0;
  logic        trig_btn = 1'b0;
  logic [7:0]  adc      = 8'h80;
  logic [7:0]  pitch    = 8'h00;
  logic [31:0] seed     = 32'h0000_0044;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  mem_rdata;
  gss_mem_t    mem_req;
  logic [7:0]  dac;
  logic        led;
  logic [31:0] rd;
  int          err_total   = 0;
  int          checks_done = 0;
  gss_mem_t    acc_q[$];

  always #50 mclk = ~mclk;

  gss_seq #(.CLIP_CYCLES(CLIPN), .EXIT_CYCLES(EXITN)) dut (
    .MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .GATE_IN(gate_in), .TRIG_BTN(trig_btn),
    .ADC_DATA(adc), .PITCH_CV(pitch), .MEM_RDATA(mem_rdata),
    .MEM_REQ(mem_req), .DAC_DATA(dac), .LED(led));

  gss_mem_model mem (.clk(mclk), .req(mem_req), .rdata(mem_rdata));

  // log of every memory access, the model's view of the sequence
  always @(posedge mclk) begin
    if (!rst && (mem_req.we || mem_req.re)) begin
      acc_q.push_back(mem_req);
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // every open-ended wait goes through here so that a hang ends the run
  task automatic step(inout int n);
    @(posedge mclk);
    n++;
    if (n > 60000) begin
      chk(32'(n), 32'h0000_0000);
      summarize();
    end
  endtask : step

  task automatic rdy();
    int n;
    n = 0;
    step(n);
    while (hreadyout !== 1'b1) step(n);
  endtask : rdy

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : bus

  task automatic wait_acc(input int k);
    int n;
    n = 0;
    while (acc_q.size() < k) step(n);
  endtask : wait_acc

  initial begin
    int n;
    int m;
    int k;
    int r;
    logic [7:0] t;
    logic [7:0] p;
    logic [7:0] v;
    logic ok;
    int ends[$];
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(hrdata, 32'h0000_0000);
    chk({5'h00, mem_req}, 32'h0000_0000);
    chk({23'h00_0000, led, dac}, 32'h0000_0000);
    chk({30'h0000_0000, hresp, hreadyout}, 32'h0000_0001);
    bus(1'b0, OFS_CTRL, 0);
    chk(rd, 32'(CTRL_RST));
    bus(1'b0, OFS_TUNE, 0);
    chk(rd, 32'(TUNE_RST));
    bus(1'b0, 8'h10, 0);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, OFS_CTRL, 32'(CTL[i]));
      bus(1'b0, OFS_STATUS, 0);
      chk(32'(rd[5:3]), 32'(MD[i]));
    end
    for (int i = 0; i < 6; i++) begin
      t = (i == 0) ? 8'hFF : 8'(xs());
      p = (i == 0) ? 8'h01 : 8'(xs());
      bus(1'b1, OFS_TUNE, 32'(t));
      pitch <= p;
      repeat (4) @(posedge mclk);
      bus(1'b0, OFS_STATUS, 0);
      chk(32'(rd[15:8]), (t + p > 255) ? 255 : t + p);
    end
    // monitoring at the fastest rate, then a clip
    bus(1'b1, OFS_CTRL, 32'h0000_000C);
    bus(1'b1, OFS_TUNE, 32'h0000_00FF);
    pitch <= 8'h00;
    repeat (400) @(posedge mclk);
    chk(32'(dac), 32'h0000_0080);
    chk(32'(led), 32'h0000_0000);
    adc <= 8'hFF;
    n = 0;
    while (led !== 1'b1) step(n);
    adc <= 8'h40;
    v = dac;
    ok = 1'b1;
    n = 0;
    while (led === 1'b1) begin
      step(n);
      ok = ok & (dac === v);
    end
    chk(32'(ok), 32'h0000_0001);
    chk(32'(n >= CLIPN && n <= CLIPN + 4), 32'h0000_0001);
    repeat (400) @(posedge mclk);
    chk(32'(dac), 32'h0000_0040);
    // record into bank_two from the button, cut short by its release
    bus(1'b1, OFS_CTRL, 32'h0000_000D);
    v = 8'h10 + 8'(xs() % 224);
    adc <= v;
    acc_q.delete();
    trig_btn <= 1'b1;
    wait_acc(12);
    chk(32'(led), 32'h0000_0001);
    trig_btn <= 1'b0;
    m = acc_q.size();
    repeat (600) @(posedge mclk);
    chk(32'(acc_q.size() <= m + 1), 32'h0000_0001);
    chk(32'(led), 32'h0000_0000);
    foreach (acc_q[j]) begin
      chk(32'(acc_q[j].addr), j);
      chk(32'(acc_q[j].bank), 32'h0000_0001);
      chk({acc_q[j].we, acc_q[j].re, acc_q[j].wdata}, {2'b10, v});
    end
    // play: early fall keeps going, a new rise restarts at zero
    bus(1'b1, OFS_CTRL, 32'h0000_000A);
    acc_q.delete();
    gate_in <= 1'b1;
    wait_acc(5);
    gate_in <= 1'b0;
    wait_acc(10);
    gate_in <= 1'b1;
    m = acc_q.size();
    wait_acc(m + 4);
    repeat (3) @(posedge mclk);
    k = 0;
    r = 0;
    foreach (acc_q[j]) begin
      if (j > 0 && acc_q[j].addr == 16'h0000) begin
        chk(32'(j >= m && j <= m + 1), 32'h0000_0001);
        k = 0;
        r++;
      end
      chk({acc_q[j].re, acc_q[j].bank, acc_q[j].addr}, 32'h20000 + k);
      k++;
    end
    chk(r, 1);
    v = acc_q[$].addr[7:0] ^ acc_q[$].addr[15:8];
    chk(32'(dac), 32'(v));
    // loop play: capture, cancel and exit
    bus(1'b1, OFS_CTRL, 32'h0000_0002);
    acc_q.delete();
    gate_in <= 1'b0;
    repeat (10) @(posedge mclk);
    gate_in <= 1'b1;
    wait_acc(8);
    chk(32'(led), 32'h0000_0001);
    gate_in <= 1'b0;
    repeat (5) @(posedge mclk);
    m = acc_q.size();
    wait_acc(4 * m + 12);
    foreach (acc_q[j]) begin
      if (j > 0 && acc_q[j].addr == 16'h0000) begin
        ends.push_back(acc_q[j - 1].addr);
      end
    end
    chk(32'(ends.size() >= 2), 32'h0000_0001);
    chk(ends[1], ends[0]);
    chk(32'(ends[0] >= m - 1 && ends[0] <= m), 32'h0000_0001);
    gate_in <= 1'b1;
    acc_q.delete();
    wait_acc(m + 6);
    chk(32'(acc_q[$].addr > ends[0]), 32'h0000_0001);
    gate_in <= 1'b0;
    repeat (300) @(posedge mclk);
    gate_in <= 1'b1;
    repeat (EXITN - 30) @(posedge mclk);
    gate_in <= 1'b0;
    repeat (10) @(posedge mclk);
    acc_q.delete();
    repeat (400) @(posedge mclk);
    chk(acc_q.size(), 0);
    bus(1'b0, OFS_STATUS, 0);
    chk({30'h0, rd[2:1]}, 32'(ST_WAIT));
    // wave record: page from tune plus pitch, re-chosen at page end
    bus(1'b1, OFS_CTRL, 32'h0000_0014);
    bus(1'b1, OFS_TUNE, 32'h0000_00E6);
    pitch <= 8'h0A;
    repeat (400) @(posedge mclk);
    acc_q.delete();
    gate_in <= 1'b1;
    wait_acc(100);
    pitch <= 8'h19;
    wait_acc(260);
    gate_in <= 1'b0;
    m = acc_q.size();
    repeat (600) @(posedge mclk);
    chk(32'(acc_q.size() <= m + 1), 32'h0000_0001);
    bus(1'b0, OFS_ADDR, 0);
    chk(rd, 32'(acc_q[$].addr) + 1);
    for (int j = 0; j < 260; j++) begin
      k = (j < 256) ? 32'h0000_F000 + j : 32'h0000_FF00 + j - 256;
      chk(32'(acc_q[j].addr), k);
    end
    summarize();
  end
endmodule : gated_sampler_sequencer_bench
`default_nettype wire
